// ===== rtl/seq_pkg.sv
package seq_pkg;

  // ==========================================================
  // widths
  localparam int ADDR_W      = 16;
  localparam int FLAG_N      = 256;
  localparam int SEL_W       = 8;
  localparam int PTR_W       = 8;
  localparam int NUM_CNT_PTR = 8;
  localparam int BUS_AW      = 5;

  // ==========================================================
  // step opcodes
  localparam logic [3:0] OP_BRANCH_TEST   = 4'h8;
  localparam logic [3:0] OP_BRANCH_ENTER  = 4'h9;
  localparam logic [3:0] OP_BRANCH_RETURN = 4'hA;
  localparam logic [3:0] OP_BRANCH_MODIFY = 4'hB;
  localparam logic [3:0] OP_BRANCH_EXT    = 4'hC;

  // ==========================================================
  // test modes and extended branch modes
  localparam logic [1:0] MODE_MOVE = 2'h0;
  localparam logic [1:0] MODE_OR   = 2'h1;
  localparam logic [1:0] MODE_AND  = 2'h2;
  localparam logic [1:0] MODE_XOR  = 2'h3;
  localparam logic [1:0] EXT_ABS     = 2'h0;
  localparam logic [1:0] EXT_ABS_PTR = 2'h1;
  localparam logic [1:0] EXT_CON_PTR = 2'h2;
  localparam logic [1:0] EXT_REL     = 2'h3;

  // ==========================================================
  // step word fields (lsb positions)
  localparam int OPC_LSB   = 28;
  localparam int MODE_LSB  = 26;
  localparam int POLA_BIT  = 25;
  localparam int POLB_BIT  = 24;
  localparam int ENTER_BIT = 24;
  localparam int SELA_LSB  = 16;
  localparam int SELB_LSB  = 8;
  localparam int REL_LSB   = 0;
  localparam int PTR_LSB   = 20;
  localparam int AMT_LSB   = 16;
  localparam int EXT_LSB   = 0;

  // ==========================================================
  // flag map
  localparam logic [4:0]       ASYNC_REG     = 5'h18;
  localparam logic [SEL_W-1:0] ASYNC_BASE    = 8'hC0;
  localparam logic [SEL_W-1:0] THRU_ZERO_SEL = 8'hFF;

  // ==========================================================
  // register word indices
  localparam logic [BUS_AW-1:0] REG_STEP   = 5'h00;
  localparam logic [BUS_AW-1:0] REG_PC     = 5'h01;
  localparam logic [BUS_AW-1:0] REG_STATUS = 5'h02;
  localparam logic [BUS_AW-1:0] REG_PTR_LO = 5'h03;
  localparam logic [BUS_AW-1:0] REG_PTR_HI = 5'h04;
  localparam logic [1:0]        FLAG_BANK  = 2'h1;
  localparam int STAT_TAKEN  = 0;
  localparam int STAT_STALL  = 1;
  localparam int STAT_THRU   = 2;
  localparam int STAT_SP_LSB = 8;

  localparam logic [ADDR_W-1:0] PC_RESET = 16'h0000;

endpackage

// ===== rtl/flag_sync.sv
`timescale 1ns/1ps
module flag_sync #(
  parameter int WIDTH = 8
)(
  // clock
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             ce,
  // pins
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] flagOut
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] next_flagOut;

  // ==========================================================
  // accept a change only when stages two and three agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_flagOut[i] = (s2[i] == s3[i]) ? s3[i] : flagOut[i];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s1      <= '0;
      s2      <= '0;
      s3      <= '0;
      flagOut <= '0;
    end else if (ce) begin
      s1      <= pinIn;
      s2      <= s1;
      s3      <= s2;
      flagOut <= next_flagOut;
    end
  end

endmodule

// ===== rtl/return_stack_mem.sv
`timescale 1ns/1ps
module return_stack_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int AW    = 4
)(
  // clock
  input  wire logic             clk,
  input  wire logic             ce,
  // write port
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  // read port, one cycle latency
  input  wire logic [AW-1:0]    rdAddr,
  output logic      [WIDTH-1:0] rdData
);

  logic [WIDTH-1:0] mem [DEPTH];

  // no reset: contents are undefined until pushed
  always_ff @(posedge clk) begin
    if (ce) begin
      if (wrEn) begin
        mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
    end
  end

endmodule

// ===== rtl/microcode_branch_sequencer.sv
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module microcode_branch_sequencer
  import seq_pkg::*;
#(
  parameter int STACK_DEPTH = 16
)(
  // clock, reset, enable
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              ce,
  // avalon-mm slave
  input  wire logic [BUS_AW-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // unsynchronised flag pins
  input  wire logic [7:0]        asyncFlags,
  // control memory address
  output logic      [ADDR_W-1:0] ctrlAddr
);

  localparam int SP_W = $clog2(STACK_DEPTH);

  typedef enum logic [1:0] {BUS_IDLE, BUS_STALL, BUS_ACK} bus_e;

  // ==========================================================
  // state
  bus_e              busState;
  bus_e              next_busState;
  logic              next_wait;
  logic [31:0]       next_readdata;
  logic [ADDR_W-1:0] next_ctrlAddr;
  logic [FLAG_N-1:0] stateFlags;
  logic [FLAG_N-1:0] next_stateFlags;
  logic [PTR_W-1:0]  ptrs      [NUM_CNT_PTR];
  logic [PTR_W-1:0]  next_ptrs [NUM_CNT_PTR];
  logic [SP_W-1:0]   sp;
  logic [SP_W-1:0]   next_sp;
  logic [31:0]       lastStep;
  logic [31:0]       next_lastStep;
  logic              lastTaken;
  logic              next_lastTaken;
  logic              lastStall;
  logic              next_lastStall;
  logic              lastThru;
  logic              next_lastThru;

  // ==========================================================
  // flag view
  logic [7:0]        syncFlags;
  logic [FLAG_N-1:0] flagView;
  logic [ADDR_W-1:0] topOfStack;
  logic [SP_W-1:0]   spDec;

  flag_sync #(
    .WIDTH (8)
  ) u_flag_sync (
    .clk     (clk),
    .srst    (srst),
    .ce      (ce),
    .pinIn   (asyncFlags),
    .flagOut (syncFlags)
  );

  // async group bypasses the flag store: it follows the pins
  always_comb begin
    flagView                   = stateFlags;
    flagView[ASYNC_BASE +: 8]  = syncFlags;
  end

  function automatic logic flagAt(input logic [FLAG_N-1:0] view,
                                  input logic tz,
                                  input logic [SEL_W-1:0] sel);
    flagAt = (sel == THRU_ZERO_SEL) ? tz : view[sel];
  endfunction

  function automatic logic isAsync(input logic [SEL_W-1:0] sel);
    isAsync = (sel[7:3] == ASYNC_REG);
  endfunction

  // ==========================================================
  // step decode
  logic [31:0]       wd;
  logic [3:0]        opc;
  logic [1:0]        mode;
  logic              polA;
  logic              polB;
  logic [SEL_W-1:0]  selA;
  logic [SEL_W-1:0]  selB;
  logic [7:0]        rel;
  logic [3:0]        ptrSel;
  logic [3:0]        amt;
  logic [ADDR_W-1:0] ext;
  logic [ADDR_W-1:0] cont;
  logic [ADDR_W-1:0] relTarget;
  logic [PTR_W-1:0]  ptrVal;
  logic [ADDR_W-1:0] ptrWide;
  logic [PTR_W-1:0]  modified;
  logic [PTR_W:0]    posSum;
  logic [3:0]        amtMag;
  logic              thruZero;
  logic              fA;
  logic              fB;
  logic              aT;
  logic              bT;
  logic              cond;
  logic              stepWrite;

  assign wd        = avs_writedata;
  assign opc       = wd[OPC_LSB +: 4];
  assign mode      = wd[MODE_LSB +: 2];
  assign polA      = wd[POLA_BIT];
  assign polB      = wd[POLB_BIT];
  assign selA      = wd[SELA_LSB +: SEL_W];
  assign selB      = wd[SELB_LSB +: SEL_W];
  assign rel       = wd[REL_LSB +: 8];
  assign ptrSel    = wd[PTR_LSB +: 4];
  assign amt       = wd[AMT_LSB +: 4];
  assign ext       = wd[EXT_LSB +: ADDR_W];
  assign stepWrite = avs_write && (avs_address == REG_STEP);
  assign cont      = ctrlAddr + 1'b1;
  // offset from continuation, not current address
  assign relTarget = cont + {{(ADDR_W-8){rel[7]}}, rel};
  // pointers 8..15 are not modelled here and read as zero
  assign ptrVal    = ptrSel[3] ? '0 : ptrs[ptrSel[2:0]];
  assign ptrWide   = {{(ADDR_W-PTR_W){1'b0}}, ptrVal};
  assign modified  = ptrVal + {{(PTR_W-4){amt[3]}}, amt};
  assign posSum    = {1'b0, ptrVal} + {5'h00, amt};
  assign amtMag    = amt[3] ? 4'(~amt + 1'b1) : amt;
  // reached or crossed zero during this modification
  assign thruZero  = amt[3] ? ({4'h0, amtMag} >= ptrVal)
                            : (posSum[PTR_W] || modified == '0);
  assign fA        = flagAt(flagView, thruZero, selA);
  assign fB        = flagAt(flagView, thruZero, selB);
  assign aT        = polA ? fA : !fA;
  assign bT        = polB ? fB : !fB;

  always_comb begin
    unique case (mode)
      MODE_MOVE: cond = aT;
      MODE_OR:   cond = aT | bT;
      MODE_AND:  cond = aT & bT;
      MODE_XOR:  cond = aT ^ bT;
    endcase
  end

  logic              taken;
  logic [ADDR_W-1:0] target;
  logic              push;
  logic              pop;
  logic              doMove;
  logic              doMod;
  logic              asyncUse;
  logic              needStall;

  always_comb begin
    taken    = 1'b0;
    target   = cont;
    push     = 1'b0;
    pop      = 1'b0;
    doMove   = 1'b0;
    doMod    = 1'b0;
    asyncUse = 1'b0;
    case (opc)
      OP_BRANCH_TEST, OP_BRANCH_ENTER, OP_BRANCH_RETURN: begin
        taken    = cond;
        target   = cond ? relTarget : cont;
        doMove   = (mode == MODE_MOVE);
        asyncUse = isAsync(selA) || isAsync(selB);
        push     = (opc == OP_BRANCH_ENTER) && cond;
        if (opc == OP_BRANCH_RETURN && !cond) begin
          pop    = 1'b1;
          target = topOfStack;
        end
      end
      OP_BRANCH_MODIFY: begin
        taken    = bT;
        target   = bT ? relTarget : cont;
        doMod    = !ptrSel[3];
        asyncUse = isAsync(selB);
      end
      OP_BRANCH_EXT: begin
        unique case (mode)
          EXT_ABS: begin
            taken  = aT;
            target = aT ? ext : cont;
          end
          EXT_ABS_PTR: begin
            taken  = 1'b1;
            target = ext + ptrWide;
          end
          EXT_CON_PTR: begin
            taken  = 1'b1;
            target = cont + ptrWide;
          end
          EXT_REL: begin
            taken  = aT;
            target = aT ? cont + ext : cont;
          end
        endcase
        push     = wd[ENTER_BIT] && taken;
        asyncUse = !mode[1] ^ mode[0] ? isAsync(selA) : 1'b0;
      end
      default: ;
    endcase
    // late through-zero result or async flag: one wait cycle
    needStall = stepWrite && (asyncUse || (opc == OP_BRANCH_MODIFY
                && selB == THRU_ZERO_SEL && !bT));
  end

  // ==========================================================
  // return stack
  logic stackWr;

  assign spDec   = sp - 1'b1;
  assign stackWr = ce && busState == BUS_ACK && stepWrite && push;

  return_stack_mem #(
    .WIDTH (ADDR_W),
    .DEPTH (STACK_DEPTH),
    .AW    (SP_W)
  ) u_stack (
    .clk    (clk),
    .ce     (ce),
    .wrEn   (stackWr),
    .wrAddr (sp),
    .wrData (cont),
    .rdAddr (spDec),
    .rdData (topOfStack)
  );

  // ==========================================================
  // read mux
  logic [31:0] rdMux;

  always_comb begin
    rdMux = '0;
    if (avs_address == REG_STEP) begin
      rdMux = lastStep;
    end else if (avs_address == REG_PC) begin
      rdMux[ADDR_W-1:0] = ctrlAddr;
    end else if (avs_address == REG_STATUS) begin
      rdMux[STAT_TAKEN]           = lastTaken;
      rdMux[STAT_STALL]           = lastStall;
      rdMux[STAT_THRU]            = lastThru;
      rdMux[STAT_SP_LSB +: SP_W]  = sp;
    end else if (avs_address == REG_PTR_LO) begin
      rdMux = {ptrs[3], ptrs[2], ptrs[1], ptrs[0]};
    end else if (avs_address == REG_PTR_HI) begin
      rdMux = {ptrs[7], ptrs[6], ptrs[5], ptrs[4]};
    end else if (avs_address[4:3] == FLAG_BANK) begin
      rdMux = flagView[{avs_address[2:0], 5'h00} +: 32];
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    next_busState   = busState;
    next_wait       = avs_waitrequest;
    next_readdata   = avs_readdata;
    next_ctrlAddr   = ctrlAddr;
    next_stateFlags = stateFlags;
    next_ptrs       = ptrs;
    next_sp         = sp;
    next_lastStep   = lastStep;
    next_lastTaken  = lastTaken;
    next_lastStall  = lastStall;
    next_lastThru   = lastThru;
    unique case (busState)
      BUS_IDLE: begin
        if (avs_read || avs_write) begin
          next_busState = needStall ? BUS_STALL : BUS_ACK;
          next_wait     = needStall;
          next_readdata = rdMux;
        end
      end
      BUS_STALL: begin
        next_busState = BUS_ACK;
        next_wait     = 1'b0;
        next_readdata = rdMux;
      end
      BUS_ACK: begin
        next_busState = BUS_IDLE;
        next_wait     = 1'b1;
        if (stepWrite) begin
          next_lastStep  = wd;
          next_lastTaken = taken;
          next_lastStall = needStall;
          next_lastThru  = thruZero;
          next_ctrlAddr  = target;
          if (doMove && !isAsync(selB) && selB != THRU_ZERO_SEL) begin
            next_stateFlags[selB] = polB ? fA : !fA;
          end
          if (doMod) begin
            next_ptrs[ptrSel[2:0]] = modified;
          end
          if (push) begin
            next_sp = sp + 1'b1;
          end else if (pop) begin
            next_sp = spDec;
          end
        end else if (avs_write) begin
          if (avs_address == REG_PC) begin
            next_ctrlAddr = wd[ADDR_W-1:0];
          end else if (avs_address == REG_PTR_LO) begin
            for (int i = 0; i < 4; i++) begin
              next_ptrs[i] = wd[i*PTR_W +: PTR_W];
            end
          end else if (avs_address == REG_PTR_HI) begin
            for (int i = 0; i < 4; i++) begin
              next_ptrs[i+4] = wd[i*PTR_W +: PTR_W];
            end
          end else if (avs_address[4:3] == FLAG_BANK) begin
            next_stateFlags[{avs_address[2:0], 5'h00} +: 32] = wd;
          end
        end
      end
    endcase
  end

  // stored flags only change at the clock edge ending a step or a flag bank write
  always_ff @(posedge clk) begin
    if (srst) begin
      busState        <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
      ctrlAddr        <= PC_RESET;
      stateFlags      <= '0;
      ptrs            <= '{default: '0};
      sp              <= '0;
      lastStep        <= '0;
      lastTaken       <= 1'b0;
      lastStall       <= 1'b0;
      lastThru        <= 1'b0;
    end else if (ce) begin
      busState        <= next_busState;
      avs_waitrequest <= next_wait;
      avs_readdata    <= next_readdata;
      ctrlAddr        <= next_ctrlAddr;
      stateFlags      <= next_stateFlags;
      ptrs            <= next_ptrs;
      sp              <= next_sp;
      lastStep        <= next_lastStep;
      lastTaken       <= next_lastTaken;
      lastStall       <= next_lastStall;
      lastThru        <= next_lastThru;
    end
  end

  // ==========================================================
  // checks
  logic execAck;

  assign execAck = busState == BUS_ACK && stepWrite;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst || !ce);

  test_taken_a: assert property (
    execAck && opc == OP_BRANCH_TEST && cond
    |=> ctrlAddr == $past(relTarget))
    else $error("taken test step went to wrong address");
  test_fall_a: assert property (
    execAck && opc == OP_BRANCH_TEST && !cond
    |=> ctrlAddr == $past(cont))
    else $error("untaken test step left continuation");
  and_mode_a: assert property (
    execAck && opc == OP_BRANCH_TEST && mode == MODE_AND && !(aT && bT)
    |=> ctrlAddr == $past(cont))
    else $error("and mode branched without both flags");
  move_copy_a: assert property (
    execAck && opc == OP_BRANCH_TEST && mode == MODE_MOVE
    && !isAsync(selB) && selB != THRU_ZERO_SEL
    |=> stateFlags[$past(selB)] == ($past(polB) ? $past(fA) : !$past(fA)))
    else $error("move a to b wrong");
  enter_push_a: assert property (
    execAck && opc == OP_BRANCH_ENTER && cond
    |=> sp == $past(sp) + 1'b1 ##1 topOfStack == $past(cont, 2))
    else $error("enter did not push continuation");
  return_pop_a: assert property (
    execAck && opc == OP_BRANCH_RETURN && !cond
    |=> ctrlAddr == $past(topOfStack) && sp == $past(spDec))
    else $error("return did not pop");
  ptr_modify_a: assert property (
    execAck && opc == OP_BRANCH_MODIFY && !ptrSel[3]
    |=> ptrs[$past(ptrSel[2:0])] == $past(modified))
    else $error("pointer not modified");
  thru_stall_a: assert property (
    busState == BUS_IDLE && stepWrite && opc == OP_BRANCH_MODIFY
    && selB == THRU_ZERO_SEL && !bT
    |=> avs_waitrequest ##1 !avs_waitrequest)
    else $error("through-zero stall missing");
  ext_ptr_a: assert property (
    execAck && opc == OP_BRANCH_EXT && mode == EXT_ABS_PTR
    |=> ctrlAddr == $past(ext + ptrWide))
    else $error("absolute plus pointer wrong");
  one_cycle_a: assert property (
    busState == BUS_IDLE && (avs_read || avs_write) && !needStall
    |=> !avs_waitrequest)
    else $error("unstalled access not answered next cycle");

  cover property (execAck && opc == OP_BRANCH_RETURN && !cond);
  cover property (execAck && opc == OP_BRANCH_EXT && push);
  cover property (busState == BUS_STALL && opc == OP_BRANCH_MODIFY);
  cover property (busState == BUS_STALL && asyncUse);

endmodule

// ===== sim/flag_pins_model.sv
`timescale 1ns/1ps
// ==========================================================
// far side: processor flag pins, never issues shift steps
module flag_pins_model (
  // clock
  input  wire logic       clk,
  // bench request
  input  wire logic [7:0] setVal,
  // pins
  output logic      [7:0] pins
);
  // pins move one edge after the request, unrelated to steps
  always_ff @(posedge clk) begin
    pins <= setVal;
  end
endmodule

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench
  import seq_pkg::*;
;
  // ==========================================================
  // signals
  logic              clk = 0;
  logic              srst = 1;
  logic              ce = 1'b1;
  logic              rd = 0;
  logic              wr = 0;
  logic [BUS_AW-1:0] adr = '0;
  logic [31:0]       wdat = '0;
  logic [31:0]       rdat;
  logic              waitReq;
  logic [7:0]        pins;
  logic [7:0]        pinSet = 8'h00;
  logic [15:0]       pc;
  int                n_mismatch = 0;
  int                checks = 0;
  int                cyc = 0;

  always #10 clk = ~clk;

  // ce dropped once, with a request pending, to prove the freeze
  microcode_branch_sequencer #(.STACK_DEPTH(16)) microcode_branch_sequencer_i (
    .clk(clk), .srst(srst), .ce(ce), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdat), .avs_readdata(rdat),
    .avs_waitrequest(waitReq), .asyncFlags(pins), .ctrlAddr(pc));
  flag_pins_model flag_pins_model_i (
    .clk(clk), .setVal(pinSet), .pins(pins));

  // ==========================================================
  // helpers
  task conclude;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      conclude;
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  // request held until waitrequest seen low at an edge
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d,
           output logic [31:0] q, output int n);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitReq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task wreg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    int          n;
    bus(1'b1, a, d, q, n);
  endtask

  task rreg(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    int          n;
    bus(1'b0, a, 32'h0000_0000, q, n);
    chk("readdata", e, q);
  endtask

  function logic [31:0] sw(input logic [3:0] o, input logic [1:0] m,
                           input logic a, input logic b,
                           input logic [7:0] x, input logic [7:0] y,
                           input logic [7:0] z);
    return {o, m, a, b, x, y, z};
  endfunction

  // execute a step, then check address and wait count
  task st(input logic [31:0] w, input logic [15:0] e, input int ew);
    logic [31:0] q;
    int          n;
    bus(1'b1, REG_STEP, w, q, n);
    @(negedge clk);
    chk("ctrlAddr", {16'h0000, e}, {16'h0000, pc});
    chk("waits", ew, n);
  endtask

  // ==========================================================
  // scenarios
  task t_reset;
    rreg(REG_PC, 32'h0000_0000);
    rreg(REG_STATUS, 32'h0000_0000);
    rreg(5'h1F, 32'h0000_0000);
  endtask

  task t_test;
    wreg(REG_PC, 32'h0000_0010);
    wreg(5'h08, 32'h0000_0003);
    st(sw(OP_BRANCH_TEST, MODE_OR, 1, 1, 8'h00, 8'h02, 8'hFE), 16'h000F, 2);
    st(sw(OP_BRANCH_TEST, MODE_AND, 1, 1, 8'h00, 8'h02, 8'h7F), 16'h0010, 2);
    st(sw(OP_BRANCH_TEST, MODE_AND, 1, 0, 8'h00, 8'h02, 8'h7F), 16'h0090, 2);
    st(sw(OP_BRANCH_TEST, MODE_XOR, 1, 1, 8'h00, 8'h01, 8'h80), 16'h0091, 2);
    st(sw(OP_BRANCH_TEST, MODE_XOR, 0, 1, 8'h00, 8'h01, 8'h80), 16'h0012, 2);
    st(sw(OP_BRANCH_TEST, MODE_XOR, 1, 0, 8'h00, 8'h00, 8'h01), 16'h0014, 2);
  endtask

  task t_move;
    st(sw(OP_BRANCH_TEST, MODE_MOVE, 1, 0, 8'h00, 8'h05, 8'h01), 16'h0016, 2);
    rreg(5'h08, 32'h0000_0003);
    st(sw(OP_BRANCH_TEST, MODE_MOVE, 1, 1, 8'h00, 8'h05, 8'h01), 16'h0018, 2);
    rreg(5'h08, 32'h0000_0023);
    st(sw(OP_BRANCH_TEST, MODE_MOVE, 1, 1, 8'h02, 8'h05, 8'h01), 16'h0019, 2);
    rreg(5'h08, 32'h0000_0003);
  endtask

  task t_stack;
    wreg(REG_PC, 32'h0000_0020);
    st(sw(OP_BRANCH_ENTER, MODE_OR, 1, 1, 8'h00, 8'h02, 8'h05), 16'h0026, 2);
    rreg(REG_STATUS, 32'h0000_0105);
    st(sw(OP_BRANCH_ENTER, MODE_AND, 1, 1, 8'h00, 8'h02, 8'h05), 16'h0027, 2);
    rreg(REG_STATUS, 32'h0000_0104);
    st(sw(OP_BRANCH_RETURN, MODE_AND, 1, 1, 8'h00, 8'h02, 8'h05), 16'h0021, 2);
    rreg(REG_STATUS, 32'h0000_0004);
    st(sw(OP_BRANCH_RETURN, MODE_OR, 1, 1, 8'h00, 8'h02, 8'h02), 16'h0024, 2);
  endtask

  // through-zero tested in the modifying step itself
  task t_mod;
    wreg(REG_PC, 32'h0000_0040);
    st(sw(OP_BRANCH_MODIFY, 2'h0, 0, 0, 8'h13, 8'h02, 8'h04), 16'h0045, 2);
    rreg(REG_PTR_LO, 32'h0000_0300);
    st(sw(OP_BRANCH_MODIFY, 2'h0, 0, 1, 8'h97, 8'h02, 8'h04), 16'h0046, 2);
    rreg(REG_PTR_HI, 32'h0000_0000);
    rreg(REG_PTR_LO, 32'h0000_0300);
    st(sw(OP_BRANCH_MODIFY, 2'h0, 0, 1, 8'h18, 8'hFF, 8'h02), 16'h0049, 2);
    rreg(REG_PTR_LO, 32'h0000_FB00);
    st(sw(OP_BRANCH_MODIFY, 2'h0, 0, 1, 8'h11, 8'hFF, 8'h02), 16'h004A, 3);
  endtask

  task t_ext;
    st(sw(OP_BRANCH_EXT, EXT_ABS, 1, 0, 8'h00, 8'h12, 8'h34), 16'h1234, 2);
    st(sw(OP_BRANCH_EXT, EXT_ABS, 0, 0, 8'h00, 8'h12, 8'h34), 16'h1235, 2);
    st(sw(OP_BRANCH_EXT, EXT_ABS_PTR, 0, 1, 8'h10, 8'h10, 8'h00), 16'h10FC, 2);
    rreg(REG_STATUS, 32'h0000_0101);
    st(sw(OP_BRANCH_EXT, EXT_CON_PTR, 0, 0, 8'h10, 8'h00, 8'h00), 16'h11F9, 2);
    st(sw(OP_BRANCH_EXT, EXT_REL, 1, 0, 8'h00, 8'hFF, 8'hF0), 16'h11EA, 2);
  endtask

  // pins settle through the synchroniser before use
  task t_async;
    @(posedge clk);
    pinSet <= 8'h01;
    repeat (8) @(posedge clk);
    st(sw(OP_BRANCH_TEST, MODE_OR, 1, 1, 8'hC0, 8'hC0, 8'h03), 16'h11EE, 3);
    rreg(REG_STATUS, 32'h0000_0107);
  endtask

  // ce low holds every register, a pending request waits it out
  task t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    fork
      wreg(REG_PC, 32'h0000_0055);
      begin
        repeat (4) @(posedge clk);
        chk("frozen", 32'h0000_11EE, {16'h0000, pc});
        chk("waitReq", 32'h0000_0001, {31'h0, waitReq});
        ce <= 1'b1;
      end
    join
    @(negedge clk);
    chk("ctrlAddr", 32'h0000_0055, {16'h0000, pc});
    // undecoded opcode only moves on to the continuation
    st(sw(4'h1, MODE_MOVE, 0, 0, 8'h00, 8'h00, 8'h07), 16'h0056, 2);
    rreg(REG_STEP, 32'h1000_0007);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    t_test;
    t_move;
    t_stack;
    t_mod;
    t_ext;
    t_async;
    t_freeze;
    conclude;
  end
endmodule
